// ===== core/dual_timer_event_counter.v
// Two 16-bit timer/event counters with four modes each, source muxes and gates.
// Assumes all inputs synchronous to clk_sys and a single-cycle register port.
`include "dual_timer_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module dual_timer_event_counter (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       first_prescaled_clock,
    input  wire       peripheral_clock,
    input  wire       timer_a_count_pin,
    input  wire       timer_b_count_pin,
    input  wire       ext_irq_a_pin,
    input  wire       ext_irq_b_pin,
    input  wire       program_fetch_strobe,
    input  wire       instr_exec_strobe,
    input  wire       vector_ack_a,
    input  wire       vector_ack_b,
    output reg        timer_a_overflow_flag,
    output reg        timer_b_overflow_flag,
    output reg        timer_a_clock_enable,
    output reg        timer_b_clock_enable
);

    // Mode step: returns {overflow, high, low} after one increment
    function [16:0] step;
        input [1:0] md;
        input [7:0] hi;
        input [7:0] lo;
        reg   [5:0] l5;
        reg   [8:0] h9;
        reg   [8:0] l9;
        begin
            l5 = {1'b0, lo[4:0]} + 6'h01;
            h9 = {1'b0, hi} + {8'h00, l5[5]};
            l9 = {1'b0, lo} + 9'h001;
            case (md)
                `MODE_13BIT: begin
                    // Upper three low bits left as they are
                    step = {h9[8], h9[7:0], lo[7:5], l5[4:0]};
                end
                `MODE_16BIT: begin
                    step = {1'b0, hi, lo} + 17'h00001;
                end
                `MODE_RELOAD: begin
                    step = l9[8] ? {1'b1, hi, hi} : {1'b0, hi, l9[7:0]};
                end
                default: begin
                    step = {l9[8], hi, l9[7:0]};
                end
            endcase
        end
    endfunction

    reg  [7:0]  control_reg;
    reg  [7:0]  mode_reg;
    reg  [7:0]  sysctl_reg;
    reg  [7:0]  a_low_reg;
    reg  [7:0]  a_high_reg;
    reg  [7:0]  b_low_reg;
    reg  [7:0]  b_high_reg;
    reg         first_prescaler_prev_reg;
    reg         second_prescaler_prev_reg;
    reg         pin_a_prev_reg;
    reg         pin_b_prev_reg;

    reg  [7:0]  control_next;
    reg  [7:0]  a_low_next;
    reg  [7:0]  a_high_next;
    reg  [7:0]  b_low_next;
    reg  [7:0]  b_high_next;
    reg  [7:0]  rdata_next;
    reg         a_src;
    reg         b_src;
    reg         a_ovf;
    reg         b_ovf;
    reg  [16:0] a_res;
    reg  [16:0] b_res;
    reg  [8:0]  split_hi;

    wire [1:0]  a_mode   = {mode_reg[`TIMER_A_MODE_HI], mode_reg[`TIMER_A_MODE_LO]};
    wire [1:0]  b_mode   = {mode_reg[`TIMER_B_MODE_HI], mode_reg[`TIMER_B_MODE_LO]};
    wire [1:0]  a_srcsel = {sysctl_reg[`TIMER_A_SRC_HI], sysctl_reg[`TIMER_A_SRC_LO]};
    wire [1:0]  b_srcsel = {sysctl_reg[`TIMER_B_SRC_HI], sysctl_reg[`TIMER_B_SRC_LO]};
    wire        a_run    = control_reg[`TIMER_A_RUN_BIT];
    wire        b_run    = control_reg[`TIMER_B_RUN_BIT];
    wire        a_split  = (a_mode == `MODE_SPLIT);

    // Internal clocks arrive as levels; a rising edge is one tick
    wire        first_prescaler_tick = first_prescaled_clock & ~first_prescaler_prev_reg;
    wire        second_prescaler_tick = peripheral_clock & ~second_prescaler_prev_reg;
    // Count pins tick on the high-to-low transition
    wire        pin_a_tick = pin_a_prev_reg & ~timer_a_count_pin;
    wire        pin_b_tick = pin_b_prev_reg & ~timer_b_count_pin;

    // Gate: pin must be high while gating is on
    wire        a_en = a_run & (~mode_reg[`TIMER_A_GATE_BIT] | ext_irq_a_pin);
    wire        b_en = b_run & (~mode_reg[`TIMER_B_GATE_BIT] | ext_irq_b_pin)
                       & (b_mode != `MODE_SPLIT);

    wire        wr_ctrl = reg_wr & (reg_addr == `TIMER_CONTROL_ADDR);

    // Source selection
    always @* begin
        case (a_srcsel)
            `SRC_FIRST_PRESCALER: a_src = first_prescaler_tick;
            `SRC_COUNT_PIN:       a_src = pin_a_tick;
            `SRC_AUXILIARY:       a_src = instr_exec_strobe;
            default:              a_src = second_prescaler_tick;
        endcase
        case (b_srcsel)
            `SRC_FIRST_PRESCALER: b_src = first_prescaler_tick;
            `SRC_COUNT_PIN:       b_src = pin_b_tick;
            `SRC_AUXILIARY:       b_src = program_fetch_strobe;
            default:              b_src = second_prescaler_tick;
        endcase
        // Counter select overrides the mux with the count pin
        if (mode_reg[`TIMER_A_CT_BIT]) begin
            a_src = pin_a_tick;
        end
        if (mode_reg[`TIMER_B_CT_BIT]) begin
            b_src = pin_b_tick;
        end
    end

    // Counting and overflow
    always @* begin
        a_res       = step(a_mode, a_high_reg, a_low_reg);
        b_res       = step(b_mode, b_high_reg, b_low_reg);
        split_hi    = {1'b0, a_high_reg} + 9'h001;
        a_low_next  = a_low_reg;
        a_high_next = a_high_reg;
        b_low_next  = b_low_reg;
        b_high_next = b_high_reg;
        a_ovf       = 1'b0;
        b_ovf       = 1'b0;
        // Count bytes change only on ticks and count-byte writes, never on run writes
        if (a_en & a_src) begin
            a_low_next = a_res[7:0];
            a_ovf      = a_res[16];
            if (!a_split) begin
                a_high_next = a_res[15:8];
            end
        end
        // Split high byte is a plain timer run by B's run bit
        if (a_split & b_run & first_prescaler_tick) begin
            a_high_next = split_hi[7:0];
            b_ovf       = split_hi[8];
        end
        if (b_en & b_src) begin
            b_low_next  = b_res[7:0];
            b_high_next = b_res[15:8];
            if (!a_split) begin
                b_ovf = b_res[16];
            end
        end
        // Software write to a count byte wins over a tick
        if (reg_wr) begin
            case (reg_addr)
                `TIMER_A_LOW_ADDR:  a_low_next  = reg_wdata;
                `TIMER_A_HIGH_ADDR: a_high_next = reg_wdata;
                `TIMER_B_LOW_ADDR:  b_low_next  = reg_wdata;
                `TIMER_B_HIGH_ADDR: b_high_next = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Control register with flag set priority
    always @* begin
        control_next = wr_ctrl ? reg_wdata : control_reg;
        if (!wr_ctrl & vector_ack_a) begin
            control_next[`TIMER_A_OVF_BIT] = 1'b0;
        end
        if (!wr_ctrl & vector_ack_b) begin
            control_next[`TIMER_B_OVF_BIT] = 1'b0;
        end
        // An overflow in the clearing cycle is kept
        if (a_ovf) begin
            control_next[`TIMER_A_OVF_BIT] = 1'b1;
        end
        if (b_ovf) begin
            control_next[`TIMER_B_OVF_BIT] = 1'b1;
        end
    end

    // Read mux, unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `TIMER_CONTROL_ADDR:  rdata_next = control_reg;
            `TIMER_MODE_ADDR:     rdata_next = mode_reg;
            `SYSTEM_CONTROL_ADDR: rdata_next = sysctl_reg;
            `TIMER_A_LOW_ADDR:    rdata_next = a_low_reg;
            `TIMER_A_HIGH_ADDR:   rdata_next = a_high_reg;
            `TIMER_B_LOW_ADDR:    rdata_next = b_low_reg;
            `TIMER_B_HIGH_ADDR:   rdata_next = b_high_reg;
            default:              rdata_next = 8'h00;
        endcase
        if (!reg_rd) begin
            rdata_next = 8'h00;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            control_reg           <= `TIMER_CONTROL_RESET;
            mode_reg              <= `TIMER_MODE_RESET;
            sysctl_reg            <= `SYSTEM_CONTROL_RESET;
            a_low_reg             <= `COUNT_BYTE_RESET;
            a_high_reg            <= `COUNT_BYTE_RESET;
            b_low_reg             <= `COUNT_BYTE_RESET;
            b_high_reg            <= `COUNT_BYTE_RESET;
            first_prescaler_prev_reg         <= 1'b0;
            second_prescaler_prev_reg         <= 1'b0;
            pin_a_prev_reg        <= 1'b0;
            pin_b_prev_reg        <= 1'b0;
            reg_rdata             <= 8'h00;
            timer_a_overflow_flag <= 1'b0;
            timer_b_overflow_flag <= 1'b0;
            timer_a_clock_enable  <= 1'b0;
            timer_b_clock_enable  <= 1'b0;
        end else begin
            control_reg    <= control_next;
            if (reg_wr & (reg_addr == `TIMER_MODE_ADDR)) begin
                mode_reg <= reg_wdata;
            end
            if (reg_wr & (reg_addr == `SYSTEM_CONTROL_ADDR)) begin
                sysctl_reg <= reg_wdata;
            end
            a_low_reg      <= a_low_next;
            a_high_reg     <= a_high_next;
            b_low_reg      <= b_low_next;
            b_high_reg     <= b_high_next;
            first_prescaler_prev_reg  <= first_prescaled_clock;
            second_prescaler_prev_reg  <= peripheral_clock;
            // Pin path runs on clk_sys; no counting with the clock stopped
            pin_a_prev_reg <= timer_a_count_pin;
            pin_b_prev_reg <= timer_b_count_pin;
            reg_rdata      <= rdata_next;
            timer_a_overflow_flag <= control_next[`TIMER_A_OVF_BIT];
            timer_b_overflow_flag <= control_next[`TIMER_B_OVF_BIT];
            // Hint for an outside clock gate; counts stay in the flops
            timer_a_clock_enable  <= control_next[`TIMER_A_RUN_BIT];
            // B's run bit also drives the split high byte, so it stays the gate hint
            timer_b_clock_enable  <= control_next[`TIMER_B_RUN_BIT];
        end
    end

endmodule // dual_timer_event_counter

`default_nettype wire

// ===== include/dual_timer_regs.vh
// Register map, field positions, reset values and encodings of the dual timer.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

// Offsets
`define TIMER_CONTROL_ADDR    8'h88
`define TIMER_MODE_ADDR       8'h89
`define TIMER_A_LOW_ADDR      8'h8a
`define TIMER_B_LOW_ADDR      8'h8b
`define TIMER_A_HIGH_ADDR     8'h8c
`define TIMER_B_HIGH_ADDR     8'h8d
`define SYSTEM_CONTROL_ADDR   8'hb4

// Reset values
`define TIMER_CONTROL_RESET   8'h00
`define TIMER_MODE_RESET      8'h00
`define SYSTEM_CONTROL_RESET  8'h00
`define COUNT_BYTE_RESET      8'h00

// Timer control fields
`define TIMER_B_OVF_BIT       7
`define TIMER_B_RUN_BIT       6
`define TIMER_A_OVF_BIT       5
`define TIMER_A_RUN_BIT       4

// Timer mode fields
`define TIMER_B_GATE_BIT      7
`define TIMER_B_CT_BIT        6
`define TIMER_B_MODE_HI       5
`define TIMER_B_MODE_LO       4
`define TIMER_A_GATE_BIT      3
`define TIMER_A_CT_BIT        2
`define TIMER_A_MODE_HI       1
`define TIMER_A_MODE_LO       0

// System control fields
`define TIMER_B_SRC_HI        7
`define TIMER_B_SRC_LO        6
`define TIMER_A_SRC_HI        5
`define TIMER_A_SRC_LO        4

// Mode encodings
`define MODE_13BIT            2'b00
`define MODE_16BIT            2'b01
`define MODE_RELOAD           2'b10
`define MODE_SPLIT            2'b11

// Source encodings
`define SRC_FIRST_PRESCALER   2'b00
`define SRC_COUNT_PIN         2'b01
`define SRC_AUXILIARY         2'b10
`define SRC_SECOND_PRESCALER  2'b11

`endif

// ===== test/dual_timer_checker.sv
// Assertions on the dual timer ports.
// Assumes binding to the top module only.
`timescale 1ns/10ps
`default_nettype none
module dual_timer_checker (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       vector_ack_a,
    input wire logic       timer_a_overflow_flag,
    input wire logic       timer_b_overflow_flag,
    input wire logic       timer_a_clock_enable,
    input wire logic       timer_b_clock_enable
);
    wire logic cw = reg_wr && reg_addr == 8'h88;
    wire logic cr = reg_rd && reg_addr == 8'h88;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    reset_clear_a:
        assert property ($rose(rst_n) |-> !(timer_a_overflow_flag || timer_b_overflow_flag
            || timer_a_clock_enable || timer_b_clock_enable)) else $error("outputs not clear");
    run_a_write_a:
        assert property (cw |=> timer_a_clock_enable == $past(reg_wdata[4])) else $error("run a");
    run_b_write_a:
        assert property (cw |=> timer_b_clock_enable == $past(reg_wdata[6])) else $error("run b");
    run_read_a:
        assert property (cr |=> reg_rdata[6] == timer_b_clock_enable && reg_rdata[4] == timer_a_clock_enable)
            else $error("run readback");
    stop_a_a:
        assert property (!cw && !timer_a_clock_enable && !timer_a_overflow_flag |=> !timer_a_overflow_flag)
            else $error("flag a while stopped");
    stop_b_a:
        assert property (!cw && !timer_b_clock_enable && !timer_b_overflow_flag |=> !timer_b_overflow_flag)
            else $error("flag b while stopped");
    flag_hold_a:
        assert property (!cw && !vector_ack_a && timer_a_overflow_flag |=> timer_a_overflow_flag)
            else $error("flag a dropped");
    flag_ack_a:
        assert property (vector_ack_a && !cw && !timer_a_clock_enable |=> !timer_a_overflow_flag)
            else $error("ack ignored");
    soft_clear_a:
        assert property (cw && !reg_wdata[5] && !timer_a_clock_enable |=> !timer_a_overflow_flag)
            else $error("soft clear ignored");
endmodule // dual_timer_checker
bind dual_timer_event_counter dual_timer_checker chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .vector_ack_a, .timer_a_overflow_flag, .timer_b_overflow_flag,
    .timer_a_clock_enable, .timer_b_clock_enable);
`default_nettype wire

// ===== test/pin_source_model.sv
// Tick sources and count pins seen by the timers.
// Assumes one-cycle requests from the bench.
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic [2:0] sel,
    output var  logic [5:0] lines
);
    // Pins idle high and tick falling; clocks and strobes pulse high
    localparam logic [5:0] IDLE = 6'h0c;
    initial lines = IDLE;
    always @(posedge clk_sys) begin
        lines <= go ? IDLE ^ (6'h01 << sel) : IDLE;
    end
endmodule // pin_source_model
`default_nettype wire

// ===== test/test_dual_timer_event_counter.sv
// Self-checking bench for the dual timer event counter.
// Assumes the source model and checker beside it.
`timescale 1ns/10ps
`default_nettype none
`define check_eq(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_dual_timer_event_counter;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       irq_a = 1'b0;
    logic       ack_a = 1'b0;
    logic       ack_b = 1'b0;
    logic       go = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [5:0] lines;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic       fa;
    logic       fb;
    logic [7:0] regs [5] = '{8'h88, 8'h89, 8'hb4, 8'h8a, 8'h90};
    logic [2:0] la [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
    logic [2:0] lb [4] = '{3'h0, 3'h3, 3'h5, 3'h1};
    int         mismatches = 0;
    int         num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    pin_source_model src (.clk_sys, .go, .sel, .lines);
    dual_timer_event_counter dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata),
        .first_prescaled_clock(lines[0]), .peripheral_clock(lines[1]), .timer_a_count_pin(lines[2]),
        .timer_b_count_pin(lines[3]), .ext_irq_a_pin(irq_a), .ext_irq_b_pin(1'b0),
        .program_fetch_strobe(lines[5]), .instr_exec_strobe(lines[4]), .vector_ack_a(ack_a),
        .vector_ack_b(ack_b), .timer_a_overflow_flag(fa), .timer_b_overflow_flag(fb),
        .timer_a_clock_enable(), .timer_b_clock_enable());
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `check_eq(rv, e)
    endtask
    // Settle time after each tick covers the pin edge detector
    task automatic tk(input logic [2:0] s, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            sel <= s;
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (regs[i]) rc(regs[i], 8'h00);
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        tk(3'h0, 1);
        `check_eq(fa, 1'b1)
        rc(8'h8c, 8'h00);
        rc(8'h88, 8'h30);
        @(posedge clk_sys);
        ack_a <= 1'b1;
        @(posedge clk_sys);
        ack_a <= 1'b0;
        rc(8'h88, 8'h10);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h00);
        wr(8'h8a, 8'h1f);
        wr(8'h8c, 8'hff);
        tk(3'h0, 1);
        rc(8'h8a, 8'h1f);
        wr(8'h88, 8'h10);
        rc(8'h8a, 8'h1f);
        tk(3'h0, 1);
        rd(8'h8a);
        `check_eq(rv[4:0], 5'h00)
        rc(8'h8c, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h02);
        wr(8'h8c, 8'h5a);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        tk(3'h0, 2);
        rc(8'h8a, 8'h5a);
        rc(8'h8c, 8'h5a);
        `check_eq(fa, 1'b1)
        wr(8'h89, 8'h0a);
        tk(3'h0, 1);
        rc(8'h8a, 8'h5a);
        irq_a <= 1'b1;
        tk(3'h0, 1);
        rc(8'h8a, 8'h5b);
        wr(8'h89, 8'h06);
        tk(3'h0, 1);
        tk(3'h2, 1);
        rc(8'h8a, 8'h5c);
        wr(8'h89, 8'h22);
        wr(8'h88, 8'h50);
        for (int i = 0; i < 4; i++) begin
            wr(8'hb4, {i[1:0], i[1:0], 4'h0});
            wr(8'h8a, 8'h00);
            wr(8'h8b, 8'h00);
            tk(la[i], 1);
            tk(lb[i], 1);
            rc(8'h8a, (la[i] == lb[i]) ? 8'h02 : 8'h01);
            rc(8'h8b, (la[i] == lb[i]) ? 8'h02 : 8'h01);
        end
        wr(8'hb4, 8'h00);
        wr(8'h89, 8'h23);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        wr(8'h8c, 8'hff);
        tk(3'h0, 1);
        rc(8'h8a, 8'h01);
        rc(8'h8b, 8'h01);
        `check_eq(fb, 1'b1)
        @(posedge clk_sys);
        ack_b <= 1'b1;
        @(posedge clk_sys);
        ack_b <= 1'b0;
        @(posedge clk_sys);
        `check_eq(fb, 1'b0)
        wr(8'h89, 8'h33);
        wr(8'h88, 8'h40);
        tk(3'h0, 1);
        rc(8'h8a, 8'h01);
        rc(8'h8b, 8'h01);
        rc(8'h8c, 8'h01);
        wrap_up;
    end
endmodule // test_dual_timer_event_counter
`default_nettype wire
